// [common/bpr_pkg.sv]
// Shared constants for the bus monitor packet recorder.
// Assumes a 25 MHz clock and a Wishbone slave with word-indexed registers.
package bpr_pkg;
	// Register indexes; the byte address is four times the index.
	localparam logic [5:0] IDX_CONFIG = 6'h29;
	localparam logic [5:0] IDX_MSG_LIMIT = 6'h2a;
	localparam logic [5:0] IDX_LIST_BASE = 6'h2f;
	localparam logic [5:0] IDX_NEXT_PTR = 6'h30;
	localparam logic [5:0] IDX_LAST_ADDR = 6'h31;
	localparam logic [5:0] IDX_CONTROL = 6'h32;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h33;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h34;
	// Configuration field positions.
	localparam int CFG_FORMAT = 0;
	localparam int CFG_CHECKSUM = 1;
	localparam int CFG_EXT_FLAGS = 2;
	localparam int CFG_HT_DISABLE = 3;
	localparam int CFG_CONT_INVALID = 4;
	localparam int CFG_SRR_LO = 5;
	localparam int CFG_SRR_HI = 6;
	localparam int CFG_WIDTH = 7;
	localparam logic [CFG_WIDTH-1:0] CFG_RESET = 7'h00;
	localparam int CTRL_SOFT_RESET = 0;
	// Interrupt status bit positions.
	localparam int IRQ_MSG_DONE = 0;
	localparam int IRQ_PKT_READY = 1;
	localparam int IRQ_MSG_ABORT = 2;
	localparam int IRQ_WIDTH = 3;
	// Reset values.
	localparam logic [15:0] LIST_BASE_RESET = 16'h00b0;
	localparam logic [15:0] MSG_LIMIT_RESET = 16'h0000;
	// Buffer layout in words.
	localparam logic [15:0] PKT_HDR_WORDS = 16'h000e;
	localparam logic [3:0] PKT_HDR_LAST = 4'hd;
	localparam logic [15:0] MSG_HDR_WORDS = 16'h0007;
	localparam logic [2:0] MSG_HDR_LAST = 3'h6;
	localparam logic [15:0] BSW_OFFSET = 16'h0004;
	// Packet sync word; value is arbitrary.
	localparam logic [15:0] PKT_SYNC_WORD = 16'h5a5a;
	// Block status word flags; bits 0 and 1 are reserved unless extended.
	localparam int BSW_WORD_ERR = 9;
	localparam int BSW_TIMEOUT = 10;
	localparam int BSW_X_CONTINUED = 0;
	localparam int BSW_X_DATA_SYNC = 1;
	localparam int TIME_WIDTH = 48;
	typedef enum logic [2:0] {ST_IDLE, ST_REC, ST_MSGHDR, ST_TRAIL, ST_PKTHDR} bpr_state_type;
endpackage : bpr_pkg

// [core/bpr_msg_count.sv]
// Per-packet message counter with the end-of-packet limit compare.
// Assumes single-cycle increment and clear strobes from the recorder.
module bpr_msg_count import bpr_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic inc_i,
	input wire logic [15:0] limit_i,
	output logic [15:0] count_o,
	output logic reached_o
);
	// A zero limit never ends a packet, so it disables this criterion.
	assign reached_o = (limit_i != 16'h0000) && ((count_o + 16'h0001) >= limit_i);

	// Clear wins over increment so a finalized packet restarts from zero.
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			count_o <= 16'h0000;
		end else if (inc_i) begin
			count_o <= count_o + 16'h0001;
		end
	end
endmodule : bpr_msg_count

// [core/bpr_checksum.sv]
// Sixteen-bit additive checksum over the packet body.
// Assumes the recorder strobes add_i once per body word written.
module bpr_checksum import bpr_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic add_i,
	input wire logic [15:0] word_i,
	output logic [15:0] sum_o
);
	// The sum wraps modulo 2^16 as a plain word tally.
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			sum_o <= 16'h0000;
		end else if (add_i) begin
			sum_o <= sum_o + word_i;
		end
	end
endmodule : bpr_checksum

// [core/bpr_recorder.sv]
// Packet recorder of a bus monitor: registers, pointers and packet framing.
// Assumes an upstream word decoder that pulses one strobe per decoded word.
module bpr_recorder import bpr_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic word_valid_i,
	input wire logic word_cmd_sync_i,
	input wire logic word_parity_ok_i,
	input wire logic word_invalid_i,
	input wire logic [15:0] word_data_i,
	input wire logic msg_done_i,
	input wire logic msg_timeout_i,
	input wire logic [15:0] buffer_start_i,
	output logic ram_we_o,
	output logic [15:0] ram_addr_o,
	output logic [15:0] ram_data_o,
	output logic [15:0] packet_start_o,
	output logic irq_o
);
	logic [CFG_WIDTH-1:0] cfg;
	logic [15:0] msg_limit;
	logic [15:0] list_base;
	logic [15:0] next_ptr;
	logic [15:0] last_addr;
	logic [IRQ_WIDTH-1:0] irq_stat;
	logic [IRQ_WIDTH-1:0] irq_mask;
	bpr_state_type state;
	logic [15:0] wptr;
	logic [15:0] msg_base;
	logic [15:0] pkt_start;
	logic have_start;
	logic have_body;
	logic [3:0] idx;
	logic [15:0] word_cnt;
	logic [TIME_WIDTH-1:0] time_tag;
	logic [TIME_WIDTH-1:0] msg_time;
	logic flag_word_err;
	logic flag_timeout;
	logic flag_data_sync;
	logic [15:0] msg_count;
	logic limit_reached;
	logic [15:0] cksum;

	// Bus decode is combinational; the ack itself is registered.
	wire bus_req = cyc_i && stb_i && !ack_o;
	wire bus_wr = bus_req && we_i;
	wire [5:0] bus_idx = adr_i[7:2];
	wire wr_cfg = bus_wr && (bus_idx == IDX_CONFIG);
	wire wr_limit = bus_wr && (bus_idx == IDX_MSG_LIMIT);
	wire wr_base = bus_wr && (bus_idx == IDX_LIST_BASE);
	wire wr_ctrl = bus_wr && (bus_idx == IDX_CONTROL);
	wire wr_stat = bus_wr && (bus_idx == IDX_IRQ_STATUS);
	wire wr_mask = bus_wr && (bus_idx == IDX_IRQ_MASK);
	wire soft_rst = wr_ctrl && sel_i[0] && dat_i[CTRL_SOFT_RESET];

	// Only the low two byte lanes carry data; upper lanes read zero.
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge
	wire [15:0] cfg_merged = merge({9'h000, cfg}, dat_i, sel_i);
	// Configuration decode.
	wire pkt_mode = !cfg[CFG_FORMAT];
	wire ht_on = !cfg[CFG_HT_DISABLE];
	wire cks_on = ht_on && cfg[CFG_CHECKSUM];
	wire cont_inv = cfg[CFG_CONT_INVALID];
	wire ext_on = cfg[CFG_EXT_FLAGS];
	wire [1:0] srr = cfg[CFG_SRR_HI:CFG_SRR_LO];

	// Start test: code 00 demands command sync, other codes also take data sync.
	wire sync_ok = word_cmd_sync_i || (srr != 2'b00);
	wire start_ok = pkt_mode && word_valid_i && word_parity_ok_i && sync_ok;

	// A fresh packet reserves header room only when headers are generated.
	wire [15:0] hdr_off = ht_on ? PKT_HDR_WORDS : 16'h0000;
	wire [15:0] pkt_base = have_start ? pkt_start : buffer_start_i;
	wire [15:0] new_base = (word_cnt == 16'h0000 && msg_count == 16'h0000 && !have_body) ?
		pkt_base + hdr_off : wptr;

	// Message end and completion strobes.
	wire rec_end = (state == ST_REC) && (msg_done_i || msg_timeout_i);
	wire abort = (state == ST_REC) && word_invalid_i && !cont_inv && !rec_end;
	wire store_inv = (state == ST_REC) && word_invalid_i && cont_inv;
	wire msg_cmpl = (state == ST_MSGHDR) && (idx[2:0] == MSG_HDR_LAST);
	wire pkt_fin = msg_cmpl && limit_reached && pkt_mode;
	wire hdr_done = (state == ST_PKTHDR) && (idx == PKT_HDR_LAST);
	wire pkt_closed = (pkt_fin && !ht_on) || hdr_done;

	// Block status word: reserved positions only carry flags when extended.
	wire [15:0] bsw_std = ({15'h0000, flag_word_err} << BSW_WORD_ERR) |
		({15'h0000, flag_timeout} << BSW_TIMEOUT);
	wire [15:0] bsw_ext = ({15'h0000, cont_inv && flag_word_err} << BSW_X_CONTINUED) |
		({15'h0000, flag_data_sync} << BSW_X_DATA_SYNC);
	wire [15:0] bsw = ext_on ? (bsw_std | bsw_ext) : bsw_std;

	// Per-message header: time tag, pad, status, gap, byte length.
	logic [15:0] msg_hdr_word;
	always_comb begin
		case (idx[2:0])
			3'h0: msg_hdr_word = msg_time[15:0];
			3'h1: msg_hdr_word = msg_time[31:16];
			3'h2: msg_hdr_word = msg_time[47:32];
			3'h4: msg_hdr_word = bsw;
			3'h6: msg_hdr_word = {word_cnt[14:0], 1'b0};
			default: msg_hdr_word = 16'h0000;
		endcase
	end

	// Packet header: sync, body length, message count, start time of the last message.
	wire [15:0] body_len = wptr - pkt_start - PKT_HDR_WORDS;
	logic [15:0] pkt_hdr_word;
	always_comb begin
		case (idx)
			4'h0: pkt_hdr_word = PKT_SYNC_WORD;
			4'h2: pkt_hdr_word = body_len;
			4'h3: pkt_hdr_word = msg_count;
			4'h5: pkt_hdr_word = msg_time[15:0];
			4'h6: pkt_hdr_word = msg_time[31:16];
			4'h7: pkt_hdr_word = msg_time[47:32];
			default: pkt_hdr_word = 16'h0000;
		endcase
	end

	// Body words feed the checksum; the header and trailer do not.
	wire body_wr = (state == ST_REC && word_valid_i && !rec_end) || (store_inv && !rec_end) ||
		(state == ST_MSGHDR) || (state == ST_IDLE && start_ok);
	wire [15:0] body_word = (state == ST_MSGHDR) ? msg_hdr_word : word_data_i;

	bpr_msg_count u_count (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(soft_rst || pkt_closed),
		.inc_i(msg_cmpl),
		.limit_i(msg_limit),
		.count_o(msg_count),
		.reached_o(limit_reached)
	);

	bpr_checksum u_cksum (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(soft_rst || pkt_closed),
		.add_i(body_wr && cks_on && !abort),
		.word_i(body_word),
		.sum_o(cksum)
	);

	// Host registers; master reset only, soft reset leaves them alone.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= CFG_RESET;
			msg_limit <= MSG_LIMIT_RESET;
			list_base <= LIST_BASE_RESET;
			irq_mask <= '0;
		end else begin
			if (wr_cfg) cfg <= cfg_merged[CFG_WIDTH-1:0];
			if (wr_limit) msg_limit <= merge(msg_limit, dat_i, sel_i);
			if (wr_base) list_base <= merge(list_base, dat_i, sel_i);
			if (wr_mask && sel_i[0]) irq_mask <= dat_i[IRQ_WIDTH-1:0];
		end
	end

	// Sticky events; a new event in the clearing cycle survives the clear.
	wire [IRQ_WIDTH-1:0] irq_set = {abort, pkt_closed, msg_cmpl};
	wire [IRQ_WIDTH-1:0] irq_clr = (wr_stat && sel_i[0]) ? dat_i[IRQ_WIDTH-1:0] : '0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
		end
	end
	assign irq_o = |(irq_stat & irq_mask);

	// Read mux; unmapped indexes read zero and are still acknowledged.
	wire [15:0] rd_word =
		(bus_idx == IDX_CONFIG) ? {9'h000, cfg} :
		(bus_idx == IDX_MSG_LIMIT) ? msg_limit :
		(bus_idx == IDX_LIST_BASE) ? list_base :
		(bus_idx == IDX_NEXT_PTR) ? next_ptr :
		(bus_idx == IDX_LAST_ADDR) ? last_addr :
		(bus_idx == IDX_IRQ_STATUS) ? {13'h0000, irq_stat} :
		(bus_idx == IDX_IRQ_MASK) ? {13'h0000, irq_mask} : 16'h0000;

	// One wait state: ack follows the request by one edge and lasts one cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req;
			dat_o <= {16'h0000, rd_word};
		end
	end

	// Free-running 48-bit time base for packet mode.
	always_ff @(posedge clk_i) begin
		if (rst_i) time_tag <= '0;
		else time_tag <= time_tag + 48'h0000_0000_0001;
	end

	// Pointer registers: touched only at message completion or by resets.
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_rst) begin
			next_ptr <= 16'h0000;
			last_addr <= 16'h0000;
		end else if (msg_cmpl) begin
			next_ptr <= wptr + BSW_OFFSET;
			last_addr <= msg_base + BSW_OFFSET;
		end
	end

	// Recording sequencer and RAM write port.
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_rst) begin
			state <= ST_IDLE;
			wptr <= 16'h0000;
			msg_base <= 16'h0000;
			pkt_start <= 16'h0000;
			have_start <= 1'b0;
			have_body <= 1'b0;
			idx <= 4'h0;
			word_cnt <= 16'h0000;
			msg_time <= '0;
			flag_word_err <= 1'b0;
			flag_timeout <= 1'b0;
			flag_data_sync <= 1'b0;
			ram_we_o <= 1'b0;
			ram_addr_o <= 16'h0000;
			ram_data_o <= 16'h0000;
		end else begin
			ram_we_o <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start_ok) begin
						pkt_start <= have_body ? pkt_start : pkt_base;
						have_start <= 1'b1;
						msg_base <= new_base;
						msg_time <= time_tag;
						flag_word_err <= 1'b0;
						flag_timeout <= 1'b0;
						flag_data_sync <= !word_cmd_sync_i;
						word_cnt <= 16'h0001;
						ram_we_o <= 1'b1;
						ram_addr_o <= new_base + MSG_HDR_WORDS;
						ram_data_o <= word_data_i;
						wptr <= new_base + MSG_HDR_WORDS + 16'h0001;
						state <= ST_REC;
					end
				end
				ST_REC: begin
					if (rec_end) begin
						flag_timeout <= msg_timeout_i;
						idx <= 4'h0;
						state <= ST_MSGHDR;
					end else if (abort) begin
						wptr <= msg_base;
						word_cnt <= 16'h0000;
						state <= ST_IDLE;
					end else if (word_valid_i || store_inv) begin
						flag_word_err <= flag_word_err || store_inv;
						word_cnt <= word_cnt + 16'h0001;
						ram_we_o <= 1'b1;
						ram_addr_o <= wptr;
						ram_data_o <= word_data_i;
						wptr <= wptr + 16'h0001;
					end
				end
				ST_MSGHDR: begin
					// Seven header words plus a bare command give eight words.
					ram_we_o <= 1'b1;
					ram_addr_o <= msg_base + {12'h000, idx};
					ram_data_o <= msg_hdr_word;
					idx <= idx + 4'h1;
					if (msg_cmpl) begin
						have_body <= 1'b1;
						word_cnt <= 16'h0000;
						idx <= 4'h0;
						if (pkt_fin && ht_on) begin
							state <= ST_TRAIL;
						end else begin
							state <= ST_IDLE;
						end
						if (pkt_fin && !ht_on) begin
							pkt_start <= wptr;
							have_body <= 1'b0;
						end
					end
				end
				ST_TRAIL: begin
					ram_we_o <= 1'b1;
					ram_addr_o <= wptr;
					ram_data_o <= cks_on ? cksum : 16'h0000;
					wptr <= wptr + 16'h0001;
					state <= ST_PKTHDR;
				end
				ST_PKTHDR: begin
					ram_we_o <= 1'b1;
					ram_addr_o <= pkt_start + {12'h000, idx};
					ram_data_o <= pkt_hdr_word;
					idx <= idx + 4'h1;
					if (hdr_done) begin
						pkt_start <= wptr;
						have_body <= 1'b0;
						idx <= 4'h0;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	assign packet_start_o = pkt_start;

	// Checks on the guarded behaviour.
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held over one cycle");
	a_base_reset_value: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> list_base == 16'h00b0) else $error("list base reset wrong");
	a_next_ptr_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		!$stable(next_ptr) |-> $past(msg_cmpl) || $past(soft_rst) || $past(rst_i))
		else $error("next pointer moved without completion");
	a_last_addr_bsw: assert property (@(posedge clk_i) disable iff (rst_i)
		msg_cmpl && !soft_rst |=> last_addr == $past(msg_base) + 16'h0004)
		else $error("last address not block status word");
	a_invalid_abort: assert property (@(posedge clk_i) disable iff (rst_i)
		abort && !soft_rst |=> state == ST_IDLE && !ram_we_o)
		else $error("invalid word not aborted");
	a_invalid_stored: assert property (@(posedge clk_i) disable iff (rst_i)
		store_inv && !rec_end && !soft_rst |=> ram_we_o && ram_data_o == $past(word_data_i))
		else $error("invalid word not stored");
	a_count_restart: assert property (@(posedge clk_i) disable iff (rst_i)
		pkt_closed |=> msg_count == 16'h0000) else $error("count not restarted");
	a_header_length: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_TRAIL && !soft_rst |=> (state == ST_PKTHDR && ram_we_o)[*8])
		else $error("packet header too short");
	a_trailer_cksum: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_TRAIL && !soft_rst |=> ram_data_o == (cfg[1] ? $past(cksum) : 16'h0000))
		else $error("trailer checksum wrong");
	a_start_needs_word: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_IDLE ##1 state == ST_REC |-> $past(start_ok))
		else $error("recording started without valid word");
	a_limit_finalize: assert property (@(posedge clk_i) disable iff (rst_i)
		msg_cmpl && msg_limit == 16'h0000 |-> !pkt_fin)
		else $error("zero limit finalized a packet");
endmodule : bpr_recorder

// [test/bpr_bus_model.sv]
// Behavioural model of the monitored bus as seen through the word decoder.
// Assumes the bench calls send_msg from one thread, one message at a time.
module bpr_bus_model (
	input wire logic clk_i,
	output logic word_valid_o,
	output logic word_cmd_sync_o,
	output logic word_parity_ok_o,
	output logic word_invalid_o,
	output logic [15:0] word_data_o,
	output logic msg_done_o,
	output logic msg_timeout_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] word_q;
	logic [15:0] noise;
	// The bench sets this to close messages by a time-out instead of a done pulse.
	logic end_by_timeout;

	// Between words the data lines carry a changing pattern, so stale data is never trusted.
	assign word_data_o = (word_valid_o | word_invalid_o) ? word_q : noise;

	// All strobes start low.
	initial begin
		word_valid_o = 1'b0;
		word_cmd_sync_o = 1'b0;
		word_parity_ok_o = 1'b0;
		word_invalid_o = 1'b0;
		msg_done_o = 1'b0;
		msg_timeout_o = 1'b0;
		word_q = 16'h0000;
		noise = 16'h0000;
		end_by_timeout = 1'b0;
	end

	// Free-running scramble for the idle data lines.
	always @(posedge clk_i) begin
		noise <= noise + 16'h3b1d;
	end

	// One word every second cycle; the word at position bad (from 1) is invalid.
	task automatic send_msg(input int n, input int bad, input logic cs, input logic [15:0] d);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			word_valid_o <= (i + 1 != bad);
			word_invalid_o <= (i + 1 == bad);
			word_cmd_sync_o <= (i == 0) ? cs : 1'b0;
			word_parity_ok_o <= 1'b1;
			word_q <= d + 16'(i);
			@(posedge clk_i);
			word_valid_o <= 1'b0;
			word_invalid_o <= 1'b0;
		end
		@(posedge clk_i);
		msg_done_o <= !end_by_timeout;
		msg_timeout_o <= end_by_timeout;
		@(posedge clk_i);
		msg_done_o <= 1'b0;
		msg_timeout_o <= 1'b0;
	endtask : send_msg
endmodule : bpr_bus_model

// [test/tb.sv]
// Self-checking bench for the packet recorder.
// Assumes the bus model answers for the decoder and the bench is the Wishbone master.
module tb import bpr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, we, cyc, stb, ack, ram_we, irq;
	logic [7:0] adr;
	logic [31:0] dat, rdat;
	logic [3:0] sel;
	logic [15:0] buf_start, ram_addr, ram_data, pkt_start;
	logic wv, wcs, wpo, wiv, mdone, mto;
	logic [15:0] wdata;
	logic [31:0] seed = 32'd5957;
	int num_errors = 0;
	int num_checks = 0;
	logic [15:0] qa[$];
	logic [15:0] qd[$];
	logic [15:0] s, b, r, x, y;

	bpr_recorder u_dut (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(dat), .dat_o(rdat),
		.we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .word_valid_i(wv),
		.word_cmd_sync_i(wcs), .word_parity_ok_i(wpo), .word_invalid_i(wiv),
		.word_data_i(wdata), .msg_done_i(mdone), .msg_timeout_i(mto),
		.buffer_start_i(buf_start), .ram_we_o(ram_we), .ram_addr_o(ram_addr),
		.ram_data_o(ram_data), .packet_start_o(pkt_start), .irq_o(irq));
	bpr_bus_model u_bus (.clk_i(clk), .word_valid_o(wv), .word_cmd_sync_o(wcs),
		.word_parity_ok_o(wpo), .word_invalid_o(wiv), .word_data_o(wdata),
		.msg_done_o(mdone), .msg_timeout_o(mto));

	// Clock at 25 MHz.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Log every buffer write in order.
	always @(posedge clk) begin
		if (ram_we === 1'b1) begin
			qa.push_back(ram_addr);
			qd.push_back(ram_data);
		end
	end

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd

	task automatic wrap_up();
		if (num_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; the request holds until ack is seen, so no latency is assumed.
	task automatic wb(input logic w, input logic [5:0] idx, input logic [15:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h3;
		adr <= {idx, 2'b00};
		dat <= {16'h0000, d};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		r = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			num_errors++;
			wrap_up();
		end
	endtask : wb

	task automatic rdc(input logic [5:0] idx, input logic [15:0] e);
		wb(1'b0, idx, 16'h0000);
		chk(r, e);
	endtask : rdc

	// A message plus enough quiet bus time for headers and packet finalization.
	task automatic msg(input int n, input int bad, input logic cs);
		u_bus.send_msg(n, bad, cs, rnd());
		repeat (40) @(posedge clk);
	endtask : msg

	// Watchdog against a hang anywhere in the run.
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		adr = 8'h00;
		dat = 32'h00000000;
		x = rnd();
		s = {8'h02, x[7:0]};
		buf_start = s;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdc(IDX_CONFIG, 16'h0000);
		rdc(IDX_MSG_LIMIT, MSG_LIMIT_RESET);
		rdc(IDX_LIST_BASE, LIST_BASE_RESET);
		rdc(IDX_NEXT_PTR, 16'h0000);
		rdc(IDX_LAST_ADDR, 16'h0000);
		rdc(6'h3f, 16'h0000);
		x = rnd();
		y = rnd();
		wb(1'b1, IDX_LIST_BASE, x);
		wb(1'b1, IDX_MSG_LIMIT, y);
		wb(1'b1, IDX_NEXT_PTR, 16'hffff);
		wb(1'b1, IDX_CONTROL, 16'h0001);
		rdc(IDX_LIST_BASE, x);
		rdc(IDX_MSG_LIMIT, y);
		rdc(IDX_NEXT_PTR, 16'h0000);
		wb(1'b1, IDX_MSG_LIMIT, 16'h0000);
		wb(1'b1, IDX_CONFIG, 16'h0000);
		// Bare mode-code message behind the reserved packet header.
		b = s + PKT_HDR_WORDS;
		msg(1, 0, 1'b1);
		chk(16'(qa.size()), 16'h0008);
		chk(qa[0], b + MSG_HDR_WORDS);
		chk(qa[5], b + BSW_OFFSET);
		chk({14'h0000, qd[5][1:0]}, 16'h0000);
		rdc(IDX_NEXT_PTR, b + 16'h000c);
		rdc(IDX_LAST_ADDR, b + BSW_OFFSET);
		// Invalid word without continue aborts; pointers stay.
		wb(1'b1, IDX_IRQ_STATUS, 16'h0007);
		msg(4, 2, 1'b1);
		rdc(IDX_LAST_ADDR, b + BSW_OFFSET);
		rdc(IDX_NEXT_PTR, b + 16'h000c);
		wb(1'b0, IDX_IRQ_STATUS, 16'h0000);
		chk({15'h0000, r[IRQ_MSG_ABORT]}, 16'h0001);
		// Continue past an invalid word, extended flags on.
		wb(1'b1, IDX_CONFIG, 16'h0014);
		b = b + 16'h0008;
		qa.delete();
		qd.delete();
		msg(3, 2, 1'b1);
		chk(16'(qa.size()), 16'h000a);
		chk(qa[7], b + BSW_OFFSET);
		chk({15'h0000, qd[7][BSW_X_CONTINUED]}, 16'h0001);
		rdc(IDX_LAST_ADDR, b + BSW_OFFSET);
		// Refused starts: data sync first, then the other monitor format.
		wb(1'b1, IDX_CONFIG, 16'h0000);
		qa.delete();
		msg(2, 0, 1'b0);
		chk(16'(qa.size()), 16'h0000);
		wb(1'b1, IDX_CONFIG, 16'h0001);
		msg(2, 0, 1'b1);
		chk(16'(qa.size()), 16'h0000);
		// Headers off: the body takes the buffer from its start.
		wb(1'b1, IDX_CONTROL, 16'h0001);
		wb(1'b1, IDX_CONFIG, 16'h0008);
		msg(1, 0, 1'b1);
		chk(qa[0], s + MSG_HDR_WORDS);
		rdc(IDX_LAST_ADDR, s + BSW_OFFSET);
		// Limit of two messages: trailer, packet header, interrupt, then a fresh count.
		wb(1'b1, IDX_CONTROL, 16'h0001);
		wb(1'b1, IDX_CONFIG, 16'h0000);
		wb(1'b1, IDX_MSG_LIMIT, 16'h0002);
		wb(1'b1, IDX_IRQ_STATUS, 16'h0007);
		qa.delete();
		qd.delete();
		msg(1, 0, 1'b1);
		msg(1, 0, 1'b1);
		chk(16'(qa.size()), 16'd31);
		chk(qd[16], 16'h0000);
		for (int i = 0; i < 14; i++) begin
			chk(qa[17 + i], s + 16'(i));
		end
		chk({15'h0000, irq}, 16'h0000);
		wb(1'b1, IDX_IRQ_MASK, 16'h0002);
		chk({15'h0000, irq}, 16'h0001);
		wb(1'b1, IDX_IRQ_STATUS, 16'h0002);
		chk({15'h0000, irq}, 16'h0000);
		msg(1, 0, 1'b1);
		chk(16'(qa.size()), 16'd39);
		msg(1, 0, 1'b1);
		chk(16'(qa.size()), 16'd62);
		// Checksum on, limit of one, message closed by a time-out.
		wb(1'b1, IDX_CONFIG, 16'h0002);
		wb(1'b1, IDX_MSG_LIMIT, 16'h0001);
		qa.delete();
		qd.delete();
		u_bus.end_by_timeout = 1'b1;
		msg(1, 0, 1'b1);
		// The trailer must carry the word sum of the eight body writes before it.
		x = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			x = x + qd[i];
		end
		chk(16'(qa.size()), 16'd23);
		chk(qd[8], x);
		chk({15'h0000, qd[5][BSW_TIMEOUT]}, 16'h0001);
		wrap_up();
	end
endmodule : tb
